// ===== verilog/fels_pkg.sv
package fels_pkg;

    // Register byte addresses
    localparam logic [7:0] ADR_MODE   = 8'h00;
    localparam logic [7:0] ADR_CMD    = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_LOCKS  = 8'h0c;
    localparam logic [7:0] ADR_ISTAT  = 8'h10;
    localparam logic [7:0] ADR_IMASK  = 8'h14;

    // flash_command_reg fields
    localparam int CODE_LSB = 0;
    localparam int CODE_W   = 8;
    localparam int ARG_LSB  = 8;
    localparam int ARG_W    = 16;
    localparam int KEY_LSB  = 24;
    localparam int KEY_W    = 8;

    // command_code_field values
    localparam logic [7:0] GET_REGION_LOCK_CMD   = 8'h01;
    localparam logic [7:0] ERASE_PAGE_GROUP_CMD  = 8'h02;
    localparam logic [7:0] SET_REGION_LOCK_CMD   = 8'h03;
    localparam logic [7:0] CLEAR_REGION_LOCK_CMD = 8'h04;

    // flash_status_reg and interrupt bit positions
    localparam int EV_READY     = 0;
    localparam int EV_CMD_ERR   = 1;
    localparam int EV_LOCK_ERR  = 2;
    localparam int EV_FLASH_ERR = 3;
    localparam int EV_W         = 4;

    // flash_mode_reg bit
    localparam int MODE_RDY_IE = 0;

    // Page group: 4 pages shifted by the two low argument bits
    localparam logic [5:0] ERASE_MIN_PAGES = 6'h04;
    localparam int         GROUP_SEL_W     = 2;

    // Reset values
    localparam logic [EV_W-1:0] ISTAT_RESET = 4'h0;
    localparam logic [EV_W-1:0] IMASK_RESET = 4'h0;

    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int PAGE_ERASE_NS  = 1000;
    localparam int LOCK_WRITE_NS  = 500;
    localparam int TIMER_W        = 16;
    localparam int PAGE_ERASE_CYC = (PAGE_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOCK_WRITE_CYC = (LOCK_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== verilog/fels_op_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fels_op_timer #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         start,
    input  wire logic [W-1:0] cycles,
    output logic              done
);

    typedef struct packed {
        logic         busy;
        logic [W-1:0] cnt;
        logic         done;
    } fels_tmr_t;

    fels_tmr_t s_r;
    fels_tmr_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (start) begin
            s_nxt.busy = 1'b1;
            s_nxt.cnt  = cycles - W'(1);
        end else if (s_r.busy) begin
            if (s_r.cnt == '0) begin
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end else begin
                s_nxt.cnt = s_r.cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;

endmodule
`default_nettype wire

// ===== verilog/fels_sequencer.sv
// How it works
// - Valid erase write starts erase at once
// - Arg bits 1:0 pick 4/8/16/32 pages
// - Ready rises when erase or lock ends
// - Ready rise raises interrupt when enabled
// - Wrong key sets command error flag
// - Locked page refuses whole erase, lock error
// - Failed erase check sets flash error
// - Set lock bit blocks erase in region
// - Set-lock sets bit of page's region
// - Get-lock command returns lock bit states
// - Set-lock reports key or check errors
// - Clear-lock clears region bit, reopens region
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module fels_sequencer #(
    parameter logic [7:0] CMD_KEY         = 8'h5a,
    parameter int         NUM_REGIONS     = 32,
    parameter int         PAGES_LOG2      = 5
) (
    input  wire logic                          CLK_SYS,
    input  wire logic                          RESET,
    input  wire logic                          WB_CYC_I,
    input  wire logic                          WB_STB_I,
    input  wire logic                          WB_WE_I,
    input  wire logic [7:0]                    WB_ADR_I,
    input  wire logic [3:0]                    WB_SEL_I,
    input  wire logic [31:0]                   WB_DAT_I,
    output logic      [31:0]                   WB_DAT_O,
    output logic                               WB_ACK_O,
    output logic                               IRQ,
    output logic                               FLASH_ERASE_STB,
    output logic      [fels_pkg::ARG_W-1:0]    FLASH_PAGE,
    output logic                               FLASH_LOCK_STB,
    output logic      [$clog2(NUM_REGIONS)-1:0] FLASH_LOCK_REGION,
    output logic                               FLASH_LOCK_VALUE,
    input  wire logic                          FLASH_CHECK_FAIL
);
    import fels_pkg::*;

    localparam int RIDX_W = $clog2(NUM_REGIONS);

    typedef enum {ST_IDLE, ST_ERASE_PAGE, ST_ERASE_WAIT, ST_LOCK_WAIT} fels_state_t;

    typedef struct packed {
        fels_state_t            st;
        logic                   ack;
        logic [31:0]            dat;
        logic                   rdy_ie;
        logic [EV_W-1:0]        istat;
        logic [EV_W-1:0]        imask;
        logic                   irq;
        logic                   ready;
        logic                   cmd_err;
        logic                   lock_err;
        logic                   flash_err;
        logic [NUM_REGIONS-1:0] locks;
        logic [NUM_REGIONS-1:0] lock_result;
        logic [ARG_W-1:0]       page;
        logic [5:0]             left;
        logic                   erase_stb;
        logic                   lock_stb;
        logic [RIDX_W-1:0]      lock_idx;
        logic                   lock_val;
        logic                   tstart;
    } fels_regs_t;

    fels_regs_t s_r;
    fels_regs_t s_nxt;

    logic              tdone;
    logic              access;
    logic              commit;
    logic              wr_cmd;
    logic              rd_status;
    logic [CODE_W-1:0] code;
    logic [ARG_W-1:0]  arg;
    logic [KEY_W-1:0]  key;
    logic [5:0]        grp_cnt;
    logic [ARG_W-1:0]  grp_start;
    logic [ARG_W-1:0]  grp_last;
    logic [RIDX_W-1:0] arg_region;
    logic              grp_locked;
    logic [EV_W-1:0]   ev;
    logic [EV_W-1:0]   w1c;
    logic [31:0]       wmask;

    fels_op_timer #(
        .W (TIMER_W)
    ) u_timer (
        .clk    (CLK_SYS),
        .reset  (RESET),
        .start  (s_r.tstart),
        .cycles ((s_r.st == ST_LOCK_WAIT) ? TIMER_W'(LOCK_WRITE_CYC) : TIMER_W'(PAGE_ERASE_CYC)),
        .done   (tdone)
    );

    // Command word decode
    always_comb begin
        code       = WB_DAT_I[CODE_LSB +: CODE_W];
        arg        = WB_DAT_I[ARG_LSB +: ARG_W];
        key        = WB_DAT_I[KEY_LSB +: KEY_W];
        grp_cnt    = ERASE_MIN_PAGES << arg[GROUP_SEL_W-1:0];
        grp_start  = arg & ~ARG_W'(grp_cnt - 6'h01);
        grp_last   = grp_start + ARG_W'(grp_cnt - 6'h01);
        arg_region = RIDX_W'(arg >> PAGES_LOG2);
        // Group spans at most two adjacent regions
        grp_locked = s_r.locks[RIDX_W'(grp_start >> PAGES_LOG2)]
                   | s_r.locks[RIDX_W'(grp_last >> PAGES_LOG2)];
    end

    always_comb begin
        access    = WB_CYC_I && WB_STB_I && !s_r.ack;
        commit    = WB_CYC_I && WB_STB_I && s_r.ack;
        wr_cmd    = commit && WB_WE_I && (WB_ADR_I == ADR_CMD) && (WB_SEL_I == 4'hf);
        rd_status = commit && !WB_WE_I && (WB_ADR_I == ADR_STATUS);
        wmask     = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
    end

    always_comb begin
        s_nxt           = s_r;
        s_nxt.ack       = access;
        s_nxt.erase_stb = 1'b0;
        s_nxt.lock_stb  = 1'b0;
        s_nxt.tstart    = 1'b0;
        ev              = '0;
        w1c             = '0;

        // Read data is captured in the cycle before ack
        if (access) begin
            if (WB_ADR_I == ADR_MODE) begin
                s_nxt.dat = 32'(s_r.rdy_ie) << MODE_RDY_IE;
            end else if (WB_ADR_I == ADR_STATUS) begin
                s_nxt.dat = 32'({s_r.flash_err, s_r.lock_err, s_r.cmd_err, s_r.ready});
            end else if (WB_ADR_I == ADR_LOCKS) begin
                s_nxt.dat = 32'(s_r.lock_result);
            end else if (WB_ADR_I == ADR_ISTAT) begin
                s_nxt.dat = 32'(s_r.istat);
            end else if (WB_ADR_I == ADR_IMASK) begin
                s_nxt.dat = 32'(s_r.imask);
            end else begin
                s_nxt.dat = '0;
            end
        end

        // Error flags clear on the status read; later sets win
        if (rd_status) begin
            s_nxt.cmd_err   = 1'b0;
            s_nxt.lock_err  = 1'b0;
            s_nxt.flash_err = 1'b0;
        end

        if (commit && WB_WE_I) begin
            if (WB_ADR_I == ADR_MODE && WB_SEL_I[0]) begin
                s_nxt.rdy_ie = WB_DAT_I[MODE_RDY_IE];
            end else if (WB_ADR_I == ADR_ISTAT) begin
                w1c = WB_DAT_I[EV_W-1:0] & wmask[EV_W-1:0];
            end else if (WB_ADR_I == ADR_IMASK) begin
                s_nxt.imask = (s_r.imask & ~wmask[EV_W-1:0]) | (WB_DAT_I[EV_W-1:0] & wmask[EV_W-1:0]);
            end
        end

        case (s_r.st)
            ST_IDLE: begin
                if (wr_cmd) begin
                    if (key != CMD_KEY) begin
                        s_nxt.cmd_err  = 1'b1;
                        ev[EV_CMD_ERR] = 1'b1;
                    end else if (code == ERASE_PAGE_GROUP_CMD) begin
                        if (grp_locked) begin
                            s_nxt.lock_err  = 1'b1;
                            ev[EV_LOCK_ERR] = 1'b1;
                        end else begin
                            s_nxt.ready = 1'b0;
                            s_nxt.page  = grp_start;
                            s_nxt.left  = grp_cnt;
                            s_nxt.st    = ST_ERASE_PAGE;
                        end
                    end else if (code == SET_REGION_LOCK_CMD || code == CLEAR_REGION_LOCK_CMD) begin
                        s_nxt.ready    = 1'b0;
                        s_nxt.lock_stb = 1'b1;
                        s_nxt.lock_idx = arg_region;
                        s_nxt.lock_val = (code == SET_REGION_LOCK_CMD);
                        s_nxt.locks[arg_region] = (code == SET_REGION_LOCK_CMD);
                        s_nxt.tstart   = 1'b1;
                        s_nxt.st       = ST_LOCK_WAIT;
                    end else if (code == GET_REGION_LOCK_CMD) begin
                        s_nxt.lock_result = s_r.locks;
                    end else begin
                        s_nxt.cmd_err  = 1'b1;
                        ev[EV_CMD_ERR] = 1'b1;
                    end
                end
            end
            ST_ERASE_PAGE: begin
                s_nxt.erase_stb = 1'b1;
                s_nxt.tstart    = 1'b1;
                s_nxt.st        = ST_ERASE_WAIT;
            end
            ST_ERASE_WAIT: begin
                if (tdone) begin
                    if (s_r.left == 6'h01) begin
                        s_nxt.ready     = 1'b1;
                        ev[EV_READY]    = 1'b1;
                        if (FLASH_CHECK_FAIL) begin
                            s_nxt.flash_err  = 1'b1;
                            ev[EV_FLASH_ERR] = 1'b1;
                        end
                        s_nxt.st = ST_IDLE;
                    end else begin
                        s_nxt.page = s_r.page + ARG_W'(1);
                        s_nxt.left = s_r.left - 6'h01;
                        s_nxt.st   = ST_ERASE_PAGE;
                    end
                end
            end
            ST_LOCK_WAIT: begin
                if (tdone) begin
                    s_nxt.ready  = 1'b1;
                    ev[EV_READY] = 1'b1;
                    if (FLASH_CHECK_FAIL) begin
                        s_nxt.flash_err  = 1'b1;
                        ev[EV_FLASH_ERR] = 1'b1;
                    end
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase

        // Commands refused while busy count as command errors
        if (wr_cmd && s_r.st != ST_IDLE) begin
            s_nxt.cmd_err  = 1'b1;
            ev[EV_CMD_ERR] = 1'b1;
        end

        // Ready event only latches when enabled in the mode register
        ev[EV_READY] = ev[EV_READY] & s_r.rdy_ie;
        s_nxt.istat  = (s_r.istat & ~w1c) | ev;
        s_nxt.irq    = |(s_nxt.istat & s_nxt.imask);
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            s_r       <= '0;
            s_r.st    <= ST_IDLE;
            s_r.ready <= 1'b1;
            s_r.istat <= ISTAT_RESET;
            s_r.imask <= IMASK_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign WB_DAT_O          = s_r.dat;
    assign WB_ACK_O          = s_r.ack;
    assign IRQ               = s_r.irq;
    assign FLASH_ERASE_STB   = s_r.erase_stb;
    assign FLASH_PAGE        = s_r.page;
    assign FLASH_LOCK_STB    = s_r.lock_stb;
    assign FLASH_LOCK_REGION = s_r.lock_idx;
    assign FLASH_LOCK_VALUE  = s_r.lock_val;

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    logic idle_key_ok;
    assign idle_key_ok = wr_cmd && (key == CMD_KEY) && (s_r.st == ST_IDLE);

    ack_single_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");

    ack_after_req_a: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
        else $error("no ack one cycle after request");

    bad_key_err_a: assert property ((wr_cmd && key != CMD_KEY) |=> s_r.cmd_err)
        else $error("bad key did not set command error");

    busy_not_ready_a: assert property ((s_r.st != ST_IDLE) |-> !s_r.ready)
        else $error("ready high while operation runs");

    locked_erase_refused_a: assert property (
        (idle_key_ok && code == ERASE_PAGE_GROUP_CMD && grp_locked)
        |=> (s_r.lock_err && s_r.st == ST_IDLE) ##1 !FLASH_ERASE_STB[*2])
        else $error("locked erase not refused");

    group_size_a: assert property (
        (idle_key_ok && code == ERASE_PAGE_GROUP_CMD && !grp_locked)
        |=> (s_r.left == (ERASE_MIN_PAGES << $past(arg[GROUP_SEL_W-1:0]))) && s_r.st == ST_ERASE_PAGE
            ##1 FLASH_ERASE_STB)
        else $error("erase group size or start wrong");

    ready_irq_a: assert property (
        ($rose(s_r.ready) && $past(s_r.rdy_ie) && s_r.imask[EV_READY]) |-> IRQ)
        else $error("ready rise did not raise interrupt");

    set_lock_bit_a: assert property (
        (idle_key_ok && code == SET_REGION_LOCK_CMD) |=> s_r.locks[$past(arg_region)] && FLASH_LOCK_STB)
        else $error("set-lock did not set region bit");

    clear_lock_bit_a: assert property (
        (idle_key_ok && code == CLEAR_REGION_LOCK_CMD) |=> !s_r.locks[$past(arg_region)] && !FLASH_LOCK_VALUE)
        else $error("clear-lock did not clear region bit");

    lock_done_ready_a: assert property (
        (s_r.st == ST_LOCK_WAIT && tdone && FLASH_CHECK_FAIL) |=> s_r.ready && s_r.flash_err)
        else $error("lock end missing ready or flash error");

    erase_check_fail_a: assert property (
        (s_r.st == ST_ERASE_WAIT && tdone && s_r.left == 6'h01 && FLASH_CHECK_FAIL)
        |=> s_r.flash_err && s_r.ready)
        else $error("erase check failure not flagged");

    status_read_clear_a: assert property (
        rd_status |=> !s_r.cmd_err && !s_r.lock_err)
        else $error("status read left error flags set");

    irq_level_a: assert property (
        IRQ == |(s_r.istat & s_r.imask))
        else $error("interrupt level disagrees with status");

    locked_page_safe_a: assert property (
        FLASH_ERASE_STB |-> !s_r.locks[RIDX_W'(FLASH_PAGE >> PAGES_LOG2)])
        else $error("page erased inside a locked region");

    lock_snapshot_a: assert property (
        (idle_key_ok && code == GET_REGION_LOCK_CMD) |=> s_r.lock_result == $past(s_r.locks))
        else $error("get-lock snapshot wrong");

    busy_cmd_refused_a: assert property (
        (wr_cmd && s_r.st != ST_IDLE) |=> s_r.cmd_err && !FLASH_LOCK_STB)
        else $error("command accepted while busy");

    ready_event_a: assert property (
        ($rose(s_r.ready) && $past(s_r.rdy_ie)) |-> s_r.istat[EV_READY])
        else $error("ready rise not latched as event");

endmodule
`default_nettype wire

// ===== bench/fels_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
module fels_flash_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        clr,
    input  wire logic        erase_stb,
    input  wire logic [15:0] page,
    input  wire logic        lock_stb,
    input  wire logic [4:0]  lock_region,
    input  wire logic        lock_value,
    input  wire logic        fail_req,
    output logic             check_fail,
    output var int           erase_cnt,
    output logic      [15:0] first_page,
    output logic      [31:0] locks,
    output var int           bad_cnt
);
    // Verify outcome of the array, failing only on request
    assign check_fail = fail_req;

    always @(posedge clk) begin
        if (reset) begin
            locks <= '0;
        end else if (lock_stb === 1'b1) begin
            locks[lock_region] <= lock_value;
        end
        if (reset || clr) begin
            erase_cnt <= 0;
            bad_cnt <= 0;
            first_page <= '0;
        end else if (erase_stb === 1'b1) begin
            if (erase_cnt == 0) begin
                first_page <= page;
            end
            erase_cnt <= erase_cnt + 1;
            // Page erased inside a locked region
            if (locks[page[9:5]] !== 1'b0) begin
                bad_cnt <= bad_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== bench/test_flash_erase_lock_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module test_flash_erase_lock_sequencer;
    import fels_pkg::*;
    localparam logic [7:0]  KEY  = 8'h5a;
    localparam logic [31:0] RDY  = 32'h1 << EV_READY;
    localparam logic [31:0] CERR = 32'h1 << EV_CMD_ERR;
    localparam logic [31:0] LERR = 32'h1 << EV_LOCK_ERR;
    localparam logic [31:0] FERR = 32'h1 << EV_FLASH_ERR;
    typedef struct packed {logic [31:0] exp; logic [31:0] msk;} fels_note_t;

    logic        CLK_SYS, RESET, cyc, stb, we, ack, irq, estb, lstb, lval, cfail, fail_req, clr;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dati, dato, q, locks;
    logic [15:0] page, first_page, lp, arg;
    logic [4:0]  lreg;
    int          erase_cnt, bad_cnt, fails, samples_checked, g, n;
    fels_note_t  notes[$];
    fels_note_t  nt;

    fels_sequencer #(.CMD_KEY(KEY), .NUM_REGIONS(32), .PAGES_LOG2(5)) u_dut (
        .CLK_SYS(CLK_SYS), .RESET(RESET), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack),
        .IRQ(irq), .FLASH_ERASE_STB(estb), .FLASH_PAGE(page), .FLASH_LOCK_STB(lstb),
        .FLASH_LOCK_REGION(lreg), .FLASH_LOCK_VALUE(lval), .FLASH_CHECK_FAIL(cfail));

    fels_flash_model u_flash (
        .clk(CLK_SYS), .reset(RESET), .clr(clr), .erase_stb(estb), .page(page),
        .lock_stb(lstb), .lock_region(lreg), .lock_value(lval), .fail_req(fail_req),
        .check_fail(cfail), .erase_cnt(erase_cnt), .first_page(first_page),
        .locks(locks), .bad_cnt(bad_cnt));

    always #5 CLK_SYS = ~CLK_SYS;

    task automatic print_verdict;
        $display("Checked %0d, failed %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask

    // Read results are compared against the oldest note
    always @(posedge CLK_SYS) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            nt = notes.pop_front();
            if (nt.msk != '0) begin
                samples_checked++;
                if ((dato & nt.msk) !== nt.exp) begin
                    fails++;
                    $display("FAIL %0t read %h expected %h", $time, dato & nt.msk, nt.exp);
                end
            end
        end
    end

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge CLK_SYS);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dati <= d;
        sel <= s;
        do begin
            @(posedge CLK_SYS);
        end while (ack !== 1'b1);
        q = dato;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'hf);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        notes.push_back('{exp: e, msk: m});
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    // Polls the sticky ready event, which reading does not clear
    task automatic wait_ready;
        int k;
        for (k = 0; k < 2000; k++) begin
            rd(ADR_ISTAT, 32'h0, 32'h0);
            if (q[EV_READY] === 1'b1) break;
        end
        chk(k < 2000, "ready never came");
    endtask

    task automatic erase(input logic [15:0] a);
        clr <= 1'b1;
        @(posedge CLK_SYS);
        clr <= 1'b0;
        wr(ADR_CMD, {KEY, a, ERASE_PAGE_GROUP_CMD});
    endtask

    initial begin
        #(60000 * 10);
        fails++;
        print_verdict;
    end

    initial begin
        CLK_SYS = 1'b0;
        RESET = 1'b1;
        {cyc, stb, we, fail_req, clr} = '0;
        adr = '0;
        sel = '0;
        dati = '0;
        void'($urandom(32'h2f52ce4b));
        repeat (3) @(posedge CLK_SYS);
        RESET <= 1'b0;
        rd(ADR_STATUS, RDY, 32'hf);
        rd(ADR_MODE, 32'h0, 32'h1);
        rd(ADR_ISTAT, ISTAT_RESET, 32'hf);
        rd(ADR_IMASK, IMASK_RESET, 32'hf);
        rd(8'h20, 32'h0, 32'hffffffff);
        wr(ADR_CMD, {8'ha5, 16'h0, ERASE_PAGE_GROUP_CMD});
        rd(ADR_STATUS, RDY | CERR, 32'hf);
        rd(ADR_STATUS, RDY, 32'hf);
        chk(erase_cnt == 0, "erase on bad key");
        wr(ADR_MODE, 32'h1 << MODE_RDY_IE);
        wr(ADR_IMASK, RDY);
        // Random pages in large sectors, every group size
        for (g = 0; g < 4; g++) begin
            lp = 16'($urandom_range(1023, 0));
            arg = {lp[15:2], 2'(g)};
            n = 4 << g;
            erase(arg);
            rd(ADR_STATUS, 32'h0, RDY);
            wait_ready;
            chk(irq === 1'b1, "no ready irq");
            chk(erase_cnt == n, "page count");
            chk(first_page === (arg & ~16'(n - 1)), "first page");
            wr(ADR_ISTAT, RDY);
            rd(ADR_STATUS, RDY, 32'hf);
            chk(irq === 1'b0, "irq not cleared");
        end
        lp = 16'($urandom_range(1023, 0));
        wr(ADR_CMD, {KEY, lp, SET_REGION_LOCK_CMD});
        rd(ADR_STATUS, 32'h0, RDY);
        // Command while the lock write runs is refused
        wr(ADR_CMD, {KEY, lp, CLEAR_REGION_LOCK_CMD});
        wait_ready;
        wr(ADR_ISTAT, RDY);
        rd(ADR_STATUS, RDY | CERR, 32'hf);
        chk(locks[lp[9:5]] === 1'b1, "lock not set");
        wr(ADR_CMD, {KEY, 16'h0, GET_REGION_LOCK_CMD});
        rd(ADR_LOCKS, 32'h1 << lp[9:5], 32'hffffffff);
        erase({lp[15:2], 2'd3});
        rd(ADR_STATUS, RDY | LERR, 32'hf);
        chk(erase_cnt == 0 && bad_cnt == 0, "locked erase ran");
        wr(ADR_CMD, {KEY, lp, CLEAR_REGION_LOCK_CMD});
        wait_ready;
        wr(ADR_ISTAT, RDY);
        wr(ADR_CMD, {KEY, 16'h0, GET_REGION_LOCK_CMD});
        rd(ADR_LOCKS, 32'h0, 32'hffffffff);
        erase({lp[15:2], 2'd0});
        wait_ready;
        wr(ADR_ISTAT, RDY);
        chk(erase_cnt == 4 && bad_cnt == 0, "unlocked erase");
        wr(ADR_IMASK, 32'h0);
        fail_req <= 1'b1;
        erase(lp);
        wait_ready;
        chk(irq === 1'b0, "masked irq");
        rd(ADR_STATUS, RDY | FERR, 32'hf);
        wr(ADR_IMASK, RDY);
        repeat (2) @(posedge CLK_SYS);
        chk(irq === 1'b1, "unmasked irq");
        wr(ADR_ISTAT, 32'hf);
        wr(ADR_CMD, {KEY, lp, SET_REGION_LOCK_CMD});
        wait_ready;
        rd(ADR_STATUS, RDY | FERR, 32'hf);
        fail_req <= 1'b0;
        wr(ADR_CMD, {8'h00, lp, SET_REGION_LOCK_CMD});
        rd(ADR_STATUS, RDY | CERR, 32'hf);
        wait (notes.size() == 0);
        print_verdict;
    end
endmodule
`default_nettype wire
